// ---- common/scan_sel_cfg.svh ----
// Purpose: constants of the multidrop scan selection block
// Assumes: eight-bit instruction register, seven slot address bits
// Notes: opcodes and address codes of the backplane test bus
`ifndef SCAN_SEL_CFG_SVH
`define SCAN_SEL_CFG_SVH

`define SLOT_WIDTH 7
`define IR_WIDTH 8
`define DR_MAX_WIDTH 32
`define IR_CAPTURE_VALUE 8'h01

`define ADDR_INTERROGATE 7'h3a
`define ADDR_BROADCAST 7'h3b
`define ADDR_GROUP_BASE 5'h0f

`define OP_BYPASS 8'hff
`define OP_EXTEST 8'h00
`define OP_SAMPLE 8'h81
`define OP_IDCODE 8'haa
`define OP_RETURN_WAIT 8'hc3
`define OP_PORT_CONFIG_SELECT 8'h8e
`define OP_GROUP_REGISTER_SELECT 8'h03
`define OP_COMPACTOR_SELECT 8'hc9
`define OP_TICK_COUNTER_SELECT 8'hce

`define LEN_BYPASS 6'd1
`define LEN_BOUNDARY 6'd8
`define LEN_IDENT 6'd32
`define LEN_MODE 6'd8
`define LEN_GROUP 6'd2
`define LEN_COMPACTOR 6'd16
`define LEN_COUNTER 6'd32

// arbitrary neutral identification value
`define IDENT_CODE 32'h1234_5001
`define MODE_RESET 8'h00
`define GROUP_RESET 2'h0
`define LOCAL_TMS_PARKED 3'h7

`endif

// ---- common/scan_sel_pkg.sv ----
// Purpose: types of the multidrop scan selection block
// Assumes: constants come from scan_sel_cfg.svh
// Notes: none
package scan_sel_pkg;

    typedef enum logic [3:0] {
        tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr,
        tap_pause_dr, tap_exit2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_shift_ir,
        tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
    } tap_state_t;

    typedef enum logic [2:0] {
        sel_wait, sel_single, sel_shared, sel_unselected, sel_interrogate
    } sel_state_t;

    typedef enum logic [2:0] {
        dr_bypass, dr_boundary, dr_ident, dr_mode, dr_group, dr_compactor, dr_counter
    } dr_sel_t;

    typedef struct packed {
        logic tms;
        logic tdi;
    } link_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
        logic tdo_weak_one;
    } link_out_t;

    typedef struct packed {
        logic selected;
        logic shared;
        logic interrogating;
    } sel_status_t;

endpackage

// ---- rtl/level_sync.sv ----
// Purpose: two-flop synchroniser for a slowly changing word
// Assumes: the source word changes rarely, all its bits at once
// Notes: first stage read only by second stage; output follows two equal samples
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] prev;
        logic [W-1:0] held;
    } sync_t;

    sync_t cur;
    sync_t nxt;

    always_comb begin
        nxt.meta = din;
        nxt.stable = cur.meta;
        nxt.prev = cur.stable;
        // a word is taken only when two samples agree, so it never arrives split
        nxt.held = (cur.stable == cur.prev) ? cur.stable : cur.held;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign dout = cur.held;
endmodule
`default_nettype wire

// ---- rtl/scan_select_bridge.sv ----
// Purpose: selection and instruction routing of a multidrop scan bridge
// Assumes: tck is the backplane test clock, clock the system clock
// Notes: data out changes on the falling edge of tck
`timescale 1ns/10ps
`default_nettype none
`include "scan_sel_cfg.svh"
module scan_select_bridge (
    input wire logic clock,
    input wire logic rst,
    input wire logic tck,
    input wire scan_sel_pkg::link_in_t link_in,
    input wire logic [6:0] slot,
    input wire logic local_oe_n,
    output scan_sel_pkg::link_out_t link_out,
    output logic [2:0] local_tms,
    output scan_sel_pkg::sel_status_t status
);
    import scan_sel_pkg::*;

    typedef struct packed {
        tap_state_t tap;
        sel_state_t sel;
        logic [`IR_WIDTH-1:0] ir_shift;
        logic [`IR_WIDTH-1:0] ir;
        logic [`DR_MAX_WIDTH-1:0] dr_shift;
        logic [7:0] mode;
        logic [1:0] group;
        logic [15:0] sig;
        logic [31:0] count;
        logic [2:0] local_tms;
        sel_status_t status;
    } link_state_t;

    link_state_t cur;
    link_state_t nxt;
    link_out_t out_q;
    link_out_t next_out;
    logic [7:0] pins_tck;
    logic [6:0] slot_tck;
    logic oe_n_tck;

    function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
        tap_state_t n;
        n = s;
        unique case (s)
            tap_reset: n = tms ? tap_reset : tap_idle;
            tap_idle: n = tms ? tap_sel_dr : tap_idle;
            tap_sel_dr: n = tms ? tap_sel_ir : tap_cap_dr;
            tap_cap_dr: n = tms ? tap_exit1_dr : tap_shift_dr;
            tap_shift_dr: n = tms ? tap_exit1_dr : tap_shift_dr;
            tap_exit1_dr: n = tms ? tap_upd_dr : tap_pause_dr;
            tap_pause_dr: n = tms ? tap_exit2_dr : tap_pause_dr;
            tap_exit2_dr: n = tms ? tap_upd_dr : tap_shift_dr;
            tap_upd_dr: n = tms ? tap_sel_dr : tap_idle;
            tap_sel_ir: n = tms ? tap_reset : tap_cap_ir;
            tap_cap_ir: n = tms ? tap_exit1_ir : tap_shift_ir;
            tap_shift_ir: n = tms ? tap_exit1_ir : tap_shift_ir;
            tap_exit1_ir: n = tms ? tap_upd_ir : tap_pause_ir;
            tap_pause_ir: n = tms ? tap_exit2_ir : tap_pause_ir;
            tap_exit2_ir: n = tms ? tap_upd_ir : tap_shift_ir;
            tap_upd_ir: n = tms ? tap_sel_dr : tap_idle;
        endcase
        return n;
    endfunction

    // data register chosen by the active instruction
    function automatic dr_sel_t dr_of(input logic [`IR_WIDTH-1:0] op);
        dr_sel_t d;
        unique case (op)
            `OP_BYPASS: d = dr_bypass;
            `OP_EXTEST, `OP_SAMPLE: d = dr_boundary;
            `OP_IDCODE: d = dr_ident;
            `OP_PORT_CONFIG_SELECT: d = dr_mode;
            `OP_GROUP_REGISTER_SELECT: d = dr_group;
            `OP_COMPACTOR_SELECT: d = dr_compactor;
            `OP_TICK_COUNTER_SELECT: d = dr_counter;
            default: d = dr_ident;
        endcase
        return d;
    endfunction

    function automatic logic [5:0] dr_len(input dr_sel_t d);
        logic [5:0] l;
        unique case (d)
            dr_bypass: l = `LEN_BYPASS;
            dr_boundary: l = `LEN_BOUNDARY;
            dr_ident: l = `LEN_IDENT;
            dr_mode: l = `LEN_MODE;
            dr_group: l = `LEN_GROUP;
            dr_compactor: l = `LEN_COMPACTOR;
            dr_counter: l = `LEN_COUNTER;
        endcase
        return l;
    endfunction

    // serial data enters at the msb of the chosen length
    function automatic logic [`DR_MAX_WIDTH-1:0] dr_shift_in(
        input logic [`DR_MAX_WIDTH-1:0] v,
        input logic [5:0] len,
        input logic bit_in
    );
        logic [`DR_MAX_WIDTH-1:0] r;
        r = '0;
        for (int i = 0; i < `DR_MAX_WIDTH; i++) begin
            if (i == int'(len) - 1) begin
                r[i] = bit_in;
            end else if (i < int'(len) - 1) begin
                r[i] = v[i + 1];
            end
        end
        return r;
    endfunction

    function automatic logic is_selected(input sel_state_t s);
        return (s == sel_single) || (s == sel_shared);
    endfunction

    level_sync #(
        .W(8)
    ) pin_sync (
        .clk(tck),
        .rst(rst),
        .din({local_oe_n, slot}),
        .dout(pins_tck)
    );

    assign slot_tck = pins_tck[6:0];
    assign oe_n_tck = pins_tck[7];

    always_comb begin
        logic [6:0] addr;
        dr_sel_t dsel;
        addr = cur.ir_shift[6:0];
        dsel = dr_of(cur.ir);
        nxt = cur;
        nxt.tap = tap_next(cur.tap, link_in.tms);
        if (cur.tap == tap_reset) begin
            nxt.sel = sel_wait;
            nxt.ir = `OP_IDCODE;
        end else if (cur.tap == tap_cap_ir) begin
            if (cur.sel == sel_interrogate) begin
                nxt.ir_shift = {1'b1, ~slot_tck};
            end else begin
                nxt.ir_shift = `IR_CAPTURE_VALUE;
            end
        end else if (cur.tap == tap_shift_ir) begin
            // lsb leaves; unselected it is simply dropped
            nxt.ir_shift = {link_in.tdi, cur.ir_shift[`IR_WIDTH-1:1]};
        end else if (cur.tap == tap_upd_ir) begin
            if (cur.ir_shift == `OP_RETURN_WAIT) begin
                nxt.sel = sel_wait;
            end else if (cur.sel == sel_wait) begin
                if (addr == `ADDR_INTERROGATE) begin
                    nxt.sel = sel_interrogate;
                end else if (addr == `ADDR_BROADCAST) begin
                    nxt.sel = sel_shared;
                    nxt.ir = `OP_IDCODE;
                end else if (addr[6:2] == `ADDR_GROUP_BASE) begin
                    if (addr[1:0] == cur.group) begin
                        nxt.sel = sel_shared;
                        nxt.ir = `OP_IDCODE;
                    end else begin
                        nxt.sel = sel_unselected;
                    end
                end else if (addr == slot_tck) begin
                    nxt.sel = sel_single;
                    nxt.ir = `OP_IDCODE;
                end else begin
                    nxt.sel = sel_unselected;
                end
            end else if (is_selected(cur.sel)) begin
                nxt.ir = cur.ir_shift;
            end
        end else if (cur.tap == tap_cap_dr) begin
            if (is_selected(cur.sel)) begin
                unique case (dsel)
                    dr_bypass: nxt.dr_shift = '0;
                    dr_boundary: nxt.dr_shift = {24'h000000, oe_n_tck, slot_tck};
                    dr_ident: nxt.dr_shift = `IDENT_CODE;
                    dr_mode: nxt.dr_shift = {24'h000000, cur.mode};
                    dr_group: nxt.dr_shift = {30'h00000000, cur.group};
                    dr_compactor: nxt.dr_shift = {16'h0000, cur.sig};
                    dr_counter: nxt.dr_shift = cur.count;
                endcase
            end
        end else if (cur.tap == tap_shift_dr) begin
            if (is_selected(cur.sel)) begin
                nxt.dr_shift = dr_shift_in(cur.dr_shift, dr_len(dsel), link_in.tdi);
            end
        end else if (cur.tap == tap_upd_dr) begin
            if (is_selected(cur.sel)) begin
                if (dsel == dr_mode) begin
                    nxt.mode = cur.dr_shift[7:0];
                end else if (dsel == dr_group) begin
                    nxt.group = cur.dr_shift[1:0];
                end else if (dsel == dr_compactor) begin
                    nxt.sig = cur.dr_shift[15:0];
                end else if (dsel == dr_counter) begin
                    nxt.count = cur.dr_shift;
                end
            end
        end
        // local ports hold their parked level across selection
        nxt.local_tms = cur.local_tms;
        nxt.status.selected = is_selected(nxt.sel);
        nxt.status.shared = (nxt.sel == sel_shared);
        nxt.status.interrogating = (nxt.sel == sel_interrogate);
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            cur.tap <= tap_reset;
            cur.sel <= sel_wait;
            cur.ir_shift <= `IR_CAPTURE_VALUE;
            cur.ir <= `OP_IDCODE;
            cur.dr_shift <= '0;
            cur.mode <= `MODE_RESET;
            cur.group <= `GROUP_RESET;
            cur.sig <= '0;
            cur.count <= '0;
            cur.local_tms <= `LOCAL_TMS_PARKED;
            cur.status <= '0;
        end else begin
            cur <= nxt;
        end
    end

    // data out is launched on the falling edge of tck
    always_comb begin
        logic shifting_ir;
        logic shifting_dr;
        logic bit_out;
        shifting_ir = (cur.tap == tap_shift_ir);
        shifting_dr = (cur.tap == tap_shift_dr);
        bit_out = shifting_ir ? cur.ir_shift[0] : cur.dr_shift[0];
        next_out.tdo = bit_out;
        next_out.tdo_oe = 1'b0;
        next_out.tdo_weak_one = 1'b0;
        if (cur.sel == sel_single) begin
            next_out.tdo_oe = shifting_ir || shifting_dr;
        end else if (cur.sel == sel_interrogate) begin
            next_out.tdo_oe = shifting_ir && !bit_out;
            next_out.tdo_weak_one = shifting_ir && bit_out;
        end
        // shared selection keeps the driver off throughout
    end

    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            out_q <= '0;
        end else begin
            out_q <= next_out;
        end
    end

    assign link_out = out_q;
    assign local_tms = cur.local_tms;

    level_sync #(
        .W(3)
    ) status_sync (
        .clk(clock),
        .rst(rst),
        .din(cur.status),
        .dout(status)
    );
endmodule
`default_nettype wire

// ---- test/scan_select_bridge_asserts.sv ----
// Purpose: port checks of the scan selection block
// Assumes: status lags the tck domain by well under one tck period
// Notes: bound to every scan_select_bridge
`timescale 1ns/10ps
`default_nettype none
module scan_select_bridge_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic tck,
    input wire scan_sel_pkg::link_in_t link_in,
    input wire logic [6:0] slot,
    input wire logic local_oe_n,
    input wire scan_sel_pkg::link_out_t link_out,
    input wire logic [2:0] local_tms,
    input wire scan_sel_pkg::sel_status_t status
);
    import scan_sel_pkg::*;
    property p_parked;
        @(posedge tck) disable iff (rst) local_tms == 3'h7;
    endproperty
    a_parked: assert property (p_parked) else $error("local port left parked");
    property p_reset_out;
        @(posedge clock) disable iff (rst) $fell(rst) |-> status == 3'h0 && local_tms == 3'h7;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("bad state after reset");
    property p_unsel_quiet;
        @(posedge tck) disable iff (rst)
            !status.selected && !status.interrogating |-> !link_out.tdo_oe;
    endproperty
    a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected drives out");
    property p_shared_off;
        @(posedge clock) disable iff (rst) status.shared |-> !link_out.tdo_oe;
    endproperty
    a_shared_off: assert property (p_shared_off) else $error("shared selection drives");
    property p_shared_sel;
        @(posedge clock) disable iff (rst) status.shared |-> status.selected;
    endproperty
    a_shared_sel: assert property (p_shared_sel) else $error("shared but not selected");
    property p_weak;
        @(posedge tck) disable iff (rst)
            link_out.tdo_weak_one |-> !link_out.tdo_oe && status.interrogating;
    endproperty
    a_weak: assert property (p_weak) else $error("weak one out of place");
    property p_strong0;
        @(posedge tck) disable iff (rst) status.interrogating && link_out.tdo_oe |-> !link_out.tdo;
    endproperty
    a_strong0: assert property (p_strong0) else $error("strong one in interrogation");
    property p_tlr;
        @(posedge tck) disable iff (rst)
            link_in.tms [*6] |-> ##2 !status.selected && !status.interrogating;
    endproperty
    a_tlr: assert property (p_tlr) else $error("test reset left selection");
    c_single: cover property (@(posedge clock) status == 3'h4);
    c_shared: cover property (@(posedge clock) status.shared);
    c_interrog: cover property (@(posedge clock) status.interrogating);
endmodule
bind scan_select_bridge scan_select_bridge_asserts chk (.clock(clock), .rst(rst), .tck(tck),
    .link_in(link_in), .slot(slot), .local_oe_n(local_oe_n), .link_out(link_out),
    .local_tms(local_tms), .status(status));
`default_nettype wire

// ---- test/backplane_tester.sv ----
// Purpose: backplane scan tester model
// Assumes: tck 48 ns, held low between steps
// Notes: tms and tdi change while tck is low, tdo taken at the rise
`timescale 1ns/10ps
`default_nettype none
module backplane_tester (
    output logic tck,
    output scan_sel_pkg::link_in_t link_in,
    input wire scan_sel_pkg::link_out_t link_out
);
    import scan_sel_pkg::*;
    initial begin
        tck = 1'b0;
        link_in = '{tms: 1'b1, tdi: 1'b0};
    end
    task automatic step(input logic ms, input logic di, output link_out_t r);
        link_in = '{tms: ms, tdi: di};
        #24 tck = 1'b1;
        r = link_out;
        #24 tck = 1'b0;
    endtask
    // six ones into test reset, then idle
    task automatic tlr();
        link_out_t r;
        for (int i = 0; i < 6; i++) begin
            step(1'b1, 1'b0, r);
        end
        step(1'b0, 1'b0, r);
    endtask
    // idle to idle, n bits lsb first
    task automatic scan(input logic ir, input logic [63:0] din, input int n,
            output logic [63:0] dout, output logic [63:0] oe, output logic [63:0] wk);
        link_out_t r;
        dout = '0;
        oe = '0;
        wk = '0;
        step(1'b1, 1'b0, r);
        if (ir) begin
            step(1'b1, 1'b0, r);
        end
        step(1'b0, 1'b0, r);
        step(1'b0, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], r);
            dout[i] = r.tdo;
            oe[i] = r.tdo_oe;
            wk[i] = r.tdo_weak_one;
        end
        step(1'b1, 1'b0, r);
        step(1'b0, 1'b0, r);
    endtask
endmodule
`default_nettype wire

// ---- test/multidrop_scan_selection_bench.sv ----
// Purpose: self-checking bench of the scan selection block
// Assumes: slot 05, group codes 3c to 3f
// Notes: status read four clocks after each instruction scan
`timescale 1ns/10ps
`default_nettype none
`include "scan_sel_cfg.svh"
`define CHECK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module multidrop_scan_selection_bench;
    import scan_sel_pkg::*;
    localparam logic [7:0] OPS [11] = '{8'hff, 8'h00, 8'h81, 8'haa, 8'h8e, 8'h03, 8'hc9,
        8'hce, 8'he7, 8'h0c, 8'h55};
    localparam int LENS [11] = '{1, 8, 8, 32, 8, 2, 16, 32, 32, 32, 32};
    logic clock, rst, tck, local_oe_n;
    logic [6:0] slot;
    logic [2:0] local_tms;
    link_in_t link_in;
    link_out_t link_out;
    sel_status_t status;
    logic [63:0] dout, oe, wk;
    int num_errors, cmp_count;
    scan_select_bridge dut (.clock(clock), .rst(rst), .tck(tck), .link_in(link_in), .slot(slot),
        .local_oe_n(local_oe_n), .link_out(link_out), .local_tms(local_tms), .status(status));
    backplane_tester tester (.tck(tck), .link_in(link_in), .link_out(link_out));
    always #4 clock = ~clock;
    task automatic ir(input logic [7:0] v);
        tester.scan(1'b1, {56'h0, v}, 8, dout, oe, wk);
        repeat (4) @(posedge clock);
        // tck edges kept off the system clock edges
        #3;
    endtask
    task automatic dr(input logic [63:0] v, input int n);
        tester.scan(1'b0, v, n, dout, oe, wk);
    endtask
    task automatic t_direct();
        `CHECK(status, 3'h0)
        ir(8'h11);
        `CHECK(oe[7:0], 8'h00)
        ir(8'h05);
        `CHECK(status, 3'h0)
        ir(8'hc3);
        ir(8'h85);
        `CHECK(status, 3'h4)
        dr(64'h0, 32);
        `CHECK(dout[31:0], `IDENT_CODE)
        `CHECK(oe[31:0], 32'hffff_ffff)
    endtask
    task automatic t_opcodes();
        for (int i = 0; i < 11; i++) begin
            if (i == 2) begin
                @(posedge clock);
                local_oe_n <= 1'b0;
                #3;
            end
            ir(OPS[i]);
            `CHECK(dout[7:0], `IR_CAPTURE_VALUE)
            `CHECK(oe[7:0], 8'hff)
            dr(64'h5a, LENS[i] + 8);
            `CHECK(dout[LENS[i] +: 8], 8'h5a)
            if (i == 1) `CHECK(dout[7:0], 8'h85)
            if (i == 2) `CHECK(dout[7:0], 8'h05)
            if (i == 3) `CHECK(dout[31:0], `IDENT_CODE)
        end
    endtask
    task automatic t_groups();
        for (int g = 0; g < 4; g++) begin
            ir(8'hc3);
            ir(8'h05);
            ir(8'h03);
            dr(64'(g), 2);
            ir(8'hc3);
            ir(8'h3c + 8'(g));
            `CHECK(status, 3'h6)
            dr(64'h0, 32);
            `CHECK(oe[31:0], 32'h0)
        end
        ir(8'hc3);
        ir(8'h3c);
        `CHECK(status, 3'h0)
    endtask
    task automatic t_broadcast();
        ir(8'hc3);
        ir(8'h3b);
        `CHECK(status, 3'h6)
        ir(8'hc9);
        `CHECK(oe[7:0], 8'h00)
        dr(64'hbeef, 16);
        ir(8'hc3);
        ir(8'h05);
        ir(8'hc9);
        dr(64'h0, 16);
        `CHECK(dout[15:0], 16'hbeef)
    endtask
    task automatic t_interrog();
        ir(8'hc3);
        ir(8'hba);
        `CHECK(status, 3'h1)
        ir(8'hc3);
        `CHECK(wk[7:0], {1'b1, ~slot})
        `CHECK(oe[7:0], {1'b0, slot})
        `CHECK(status, 3'h0)
        ir(8'h05);
        tester.tlr();
        repeat (4) @(posedge clock);
        `CHECK(status, 3'h0)
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        slot = 7'h05;
        local_oe_n = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        #3;
        tester.tlr();
        `CHECK(local_tms, 3'h7)
        t_direct();
        t_opcodes();
        t_groups();
        t_broadcast();
        t_interrog();
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
